/* inc/ptw_pkg.sv */
// ptw_pkg: constants of the pci target window map
// assumes: 32-bit wishbone data, 34-bit system bus addresses
package ptw_pkg;
  // ----------------------------------------------------------
  // widths
  // ----------------------------------------------------------
  localparam int DW = 32;
  localparam int AW = 8;
  localparam int SAW = 34;
  localparam int NWIN = 2;
  localparam int MW = 12;
  localparam int TBW = 23;
  localparam int EAW = 28;
  localparam int NFLG = 4;
  // ----------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------
  localparam logic [AW-1:0] OFS_SYS_ERR = 8'h00;
  localparam logic [AW-1:0] OFS_TBASE1 = 8'h04;
  localparam logic [AW-1:0] OFS_TBASE2 = 8'h08;
  localparam logic [AW-1:0] OFS_WBASE1 = 8'h0c;
  localparam logic [AW-1:0] OFS_WBASE2 = 8'h10;
  localparam logic [AW-1:0] OFS_MASK1 = 8'h14;
  localparam logic [AW-1:0] OFS_MASK2 = 8'h18;
  localparam logic [AW-1:0] OFS_DIAG = 8'h1c;
  // ----------------------------------------------------------
  // field positions
  // ----------------------------------------------------------
  localparam int WIN_LO = 20;
  localparam int WEN_BIT = 19;
  localparam int SG_MAPPING_ENABLE_BIT_BIT = 18;
  localparam int TB_LO = 9;
  localparam int TB_CPU_LO = 10;
  localparam int ERR_LO = 4;
  localparam int ERR_SYS_LO = 6;
  localparam int PAGE_LO = 13;
  localparam int PTE_LO = 3;
  localparam int FLG_MEM = 0;
  localparam int FLG_UNC = 1;
  localparam int FLG_COR = 2;
  localparam int FLG_LOST = 3;
  // ----------------------------------------------------------
  // reset values
  // ----------------------------------------------------------
  localparam logic [DW-1:0] RST_WORD = 32'h0000_0000;
endpackage

/* inc/ptw_if.sv */
// ptw_if: carriers between the top and its window and log modules
// assumes: all parties run on the one system clock
`timescale 1ns/1ps
interface ptw_win_if;
  logic [ptw_pkg::MW-1:0] base;
  logic [ptw_pkg::MW-1:0] mask;
  logic [ptw_pkg::TBW-1:0] tbase;
  logic wen;
  logic sg_mapping_enable_bit;
  logic req;
  logic [ptw_pkg::DW-1:0] pci_addr;
  logic rsp_vld;
  logic rsp_hit;
  logic rsp_sg;
  logic [ptw_pkg::SAW-1:0] rsp_addr;
  modport ctl (output base, mask, tbase, wen, sg_mapping_enable_bit, req, pci_addr,
    input rsp_vld, rsp_hit, rsp_sg, rsp_addr);
  modport win (input base, mask, tbase, wen, sg_mapping_enable_bit, req, pci_addr,
    output rsp_vld, rsp_hit, rsp_sg, rsp_addr);
endinterface

interface ptw_err_if;
  logic ev_mem;
  logic ev_unc;
  logic ev_cor;
  logic [ptw_pkg::SAW-1:0] sys_addr;
  logic [ptw_pkg::NFLG-1:0] clr;
  logic [ptw_pkg::NFLG-1:0] flags;
  logic [ptw_pkg::EAW-1:0] err_addr;
  modport ctl (output ev_mem, ev_unc, ev_cor, sys_addr, clr,
    input flags, err_addr);
  modport log (input ev_mem, ev_unc, ev_cor, sys_addr, clr,
    output flags, err_addr);
endinterface

/* hdl/ptw_window.sv */
// ptw_window: hit check and address translation of one window
// assumes: config is stable while software keeps the window enabled
`timescale 1ns/1ps
module ptw_window (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // window config, lookup and answer
  ptw_win_if.win w
);
  typedef struct packed {
    logic vld;
    logic hit;
    logic sg;
    logic [ptw_pkg::SAW-1:0] addr;
  } ptw_win_st_t;
  ptw_win_st_t st_r;
  ptw_win_st_t st_nxt;
  logic [ptw_pkg::SAW-1:0] mext;
  logic [ptw_pkg::SAW-1:0] off;
  logic [ptw_pkg::SAW-1:0] tb_addr;
  // ----------------------------------------------------------
  // translation
  // ----------------------------------------------------------
  always_comb begin
    mext = {2'h0, w.mask, {ptw_pkg::WIN_LO{1'b1}}}; // [R12]
    off = mext & {2'h0, w.pci_addr};
    tb_addr = {1'b0, w.tbase, {ptw_pkg::TB_CPU_LO{1'b0}}};
    st_nxt = st_r;
    st_nxt.vld = w.req;
    // base compared only in bits the mask does not open [R06] [R12]
    st_nxt.hit = w.wen & // [R07] [R08]
      ((w.pci_addr[ptw_pkg::DW-1:ptw_pkg::WIN_LO] & ~w.mask) ==
       (w.base & ~w.mask));
    st_nxt.sg = w.sg_mapping_enable_bit;
    if (w.sg_mapping_enable_bit) begin
      // map table entry address, one 8-byte entry per page [R05] [R11]
      st_nxt.addr = tb_addr |
        {12'h000, off[ptw_pkg::DW-1:ptw_pkg::PAGE_LO],
         {ptw_pkg::PTE_LO{1'b0}}};
    end else begin
      st_nxt.addr = (tb_addr & ~mext) | off; // [R04] [R10] [R13]
    end
    if (srst) begin
      st_nxt = '0;
    end
  end
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end
  assign w.rsp_vld = st_r.vld;
  assign w.rsp_hit = st_r.hit;
  assign w.rsp_sg = st_r.sg;
  assign w.rsp_addr = st_r.addr;
endmodule

/* hdl/ptw_err_log.sv */
// ptw_err_log: dma error flags and system bus error address log
// assumes: events are one-cycle pulses on the system clock
`timescale 1ns/1ps
module ptw_err_log (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // events, clears and logged state
  ptw_err_if.log e
);
  typedef struct packed {
    logic [ptw_pkg::NFLG-1:0] flags;
    logic [ptw_pkg::EAW-1:0] addr;
  } ptw_err_st_t;
  ptw_err_st_t st_r;
  ptw_err_st_t st_nxt;
  logic [ptw_pkg::NFLG-1:0] set;
  logic any_set;
  logic ev;
  // ----------------------------------------------------------
  // capture and flags
  // ----------------------------------------------------------
  always_comb begin
    set = '0;
    set[ptw_pkg::FLG_MEM] = e.ev_mem;
    set[ptw_pkg::FLG_UNC] = e.ev_unc;
    set[ptw_pkg::FLG_COR] = e.ev_cor;
    any_set = |st_r.flags[ptw_pkg::FLG_COR:ptw_pkg::FLG_MEM];
    ev = e.ev_mem | e.ev_unc | e.ev_cor;
    st_nxt = st_r;
    if (ev && any_set) begin
      set[ptw_pkg::FLG_LOST] = 1'b1; // [R03]
    end
    if (ev && !any_set) begin
      st_nxt.addr = e.sys_addr[ptw_pkg::SAW-1:ptw_pkg::ERR_SYS_LO]; // [R01]
    end
    st_nxt.flags = (st_r.flags & ~e.clr) | set;
    if (srst) begin
      st_nxt = '0;
    end
  end
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end
  assign e.flags = st_r.flags;
  assign e.err_addr = st_r.addr;
endmodule

/* hdl/ptw_top.sv */
// ptw_top: inbound pci target windows with wishbone register access
// assumes: classic wishbone master, pci and dma sides on clk
//
// Behaviour
// (R01) dma memory or read error logs system address 33:6 in bits 31:4
// (R02) logged address is valid only while an error flag is set
// (R03) error while a flag is set keeps address, sets lost flag
// (R04) direct mapping: translated base gives window cpu base
// (R05) sg mapping: translated base gives map table base
// (R06) window base bits 31:20 give the window start address
// (R07) window enable clear: window does not respond
// (R08) window enable set: window responds to hits in range
// (R09) software clears window enable before changing window registers
// (R10) sg enable clear selects direct mapping
// (R11) sg enable set selects map table lookup
// (R12) mask bits 31:20 size the window and steer translation
// (R13) direct: masked bits from base, open bits pass from pci address
`timescale 1ns/1ps
module ptw_top (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ptw_pkg::AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ptw_pkg::DW-1:0] wb_dat_i,
  output logic [ptw_pkg::DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  // pci inbound lookup
  input wire logic pci_req,
  input wire logic [ptw_pkg::DW-1:0] pci_addr,
  output logic tgt_vld,
  output logic tgt_hit,
  output logic tgt_win,
  output logic tgt_sg,
  output logic [ptw_pkg::SAW-1:0] tgt_cpu_addr,
  // dma error events
  input wire logic memory_error_flag_ev,
  input wire logic uncorrectable_read_error_flag_ev,
  input wire logic correctable_read_error_flag_ev,
  input wire logic [ptw_pkg::SAW-1:0] system_bus_address,
  output logic err_addr_valid
);
  typedef struct packed {
    logic ack;
    logic [ptw_pkg::DW-1:0] rdata;
    logic [ptw_pkg::NWIN-1:0][ptw_pkg::TBW-1:0] tbase;
    logic [ptw_pkg::NWIN-1:0][ptw_pkg::MW-1:0] base;
    logic [ptw_pkg::NWIN-1:0] wen;
    logic [ptw_pkg::NWIN-1:0] sg_mapping_enable_bit;
    logic [ptw_pkg::NWIN-1:0][ptw_pkg::MW-1:0] mask;
    logic tvld;
    logic thit;
    logic twin;
    logic tsg;
    logic [ptw_pkg::SAW-1:0] taddr;
    logic errv;
  } ptw_top_st_t;
  ptw_top_st_t st_r;
  ptw_top_st_t st_nxt;

  ptw_win_if wif [ptw_pkg::NWIN] ();
  ptw_err_if eif ();

  logic req;
  logic wr;
  logic [ptw_pkg::DW-1:0] rd_word;
  logic [ptw_pkg::DW-1:0] wmask;
  logic [ptw_pkg::DW-1:0] wword;
  logic [ptw_pkg::NWIN-1:0] rhit;
  logic [ptw_pkg::NWIN-1:0] rsg;
  logic [ptw_pkg::NWIN-1:0][ptw_pkg::SAW-1:0] raddr;
  logic rvld;
  logic [ptw_pkg::NFLG-1:0] clr;

  // ----------------------------------------------------------
  // register word images
  // ----------------------------------------------------------
  function automatic logic [ptw_pkg::DW-1:0] tb_word(
    input logic [ptw_pkg::TBW-1:0] tb);
    logic [ptw_pkg::DW-1:0] v;
    v = ptw_pkg::RST_WORD;
    v[ptw_pkg::DW-1:ptw_pkg::TB_LO] = tb;
    return v;
  endfunction

  function automatic logic [ptw_pkg::DW-1:0] wb_word(
    input logic [ptw_pkg::MW-1:0] b,
    input logic en,
    input logic sg);
    logic [ptw_pkg::DW-1:0] v;
    v = ptw_pkg::RST_WORD;
    v[ptw_pkg::DW-1:ptw_pkg::WIN_LO] = b;
    v[ptw_pkg::WEN_BIT] = en;
    v[ptw_pkg::SG_MAPPING_ENABLE_BIT_BIT] = sg;
    return v;
  endfunction

  function automatic logic [ptw_pkg::DW-1:0] mk_word(
    input logic [ptw_pkg::MW-1:0] m);
    logic [ptw_pkg::DW-1:0] v;
    v = ptw_pkg::RST_WORD;
    v[ptw_pkg::DW-1:ptw_pkg::WIN_LO] = m;
    return v;
  endfunction

  // ----------------------------------------------------------
  // windows
  // ----------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < ptw_pkg::NWIN; gi++) begin : g_win
      assign wif[gi].base = st_r.base[gi];
      assign wif[gi].mask = st_r.mask[gi];
      assign wif[gi].tbase = st_r.tbase[gi];
      assign wif[gi].wen = st_r.wen[gi];
      assign wif[gi].sg_mapping_enable_bit = st_r.sg_mapping_enable_bit[gi];
      assign wif[gi].req = pci_req;
      assign wif[gi].pci_addr = pci_addr;
      assign rhit[gi] = wif[gi].rsp_hit;
      assign rsg[gi] = wif[gi].rsp_sg;
      assign raddr[gi] = wif[gi].rsp_addr;
      ptw_window u_win (
        .clk (clk),
        .srst (srst),
        .w (wif[gi])
      );
    end
  endgenerate
  assign rvld = wif[0].rsp_vld;

  // ----------------------------------------------------------
  // error log
  // ----------------------------------------------------------
  assign eif.ev_mem = memory_error_flag_ev;
  assign eif.ev_unc = uncorrectable_read_error_flag_ev;
  assign eif.ev_cor = correctable_read_error_flag_ev;
  assign eif.sys_addr = system_bus_address;
  assign eif.clr = clr;

  ptw_err_log u_log (
    .clk (clk),
    .srst (srst),
    .e (eif)
  );

  // ----------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------
  always_comb begin
    req = wb_cyc_i & wb_stb_i;
    wr = req & wb_we_i & st_r.ack;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wword = wb_dat_i & wmask;
    clr = '0;
    if (wr && wb_adr_i == ptw_pkg::OFS_DIAG) begin
      clr = wword[ptw_pkg::NFLG-1:0];
    end
  end

  // ----------------------------------------------------------
  // read mux
  // ----------------------------------------------------------
  always_comb begin
    rd_word = ptw_pkg::RST_WORD;
    case (wb_adr_i)
      ptw_pkg::OFS_SYS_ERR: begin
        rd_word[ptw_pkg::DW-1:ptw_pkg::ERR_LO] = eif.err_addr; // [R01]
      end
      ptw_pkg::OFS_TBASE1: begin
        rd_word = tb_word(st_r.tbase[0]);
      end
      ptw_pkg::OFS_TBASE2: begin
        rd_word = tb_word(st_r.tbase[1]);
      end
      ptw_pkg::OFS_WBASE1: begin
        rd_word = wb_word(st_r.base[0], st_r.wen[0], st_r.sg_mapping_enable_bit[0]);
      end
      ptw_pkg::OFS_WBASE2: begin
        rd_word = wb_word(st_r.base[1], st_r.wen[1], st_r.sg_mapping_enable_bit[1]);
      end
      ptw_pkg::OFS_MASK1: begin
        rd_word = mk_word(st_r.mask[0]);
      end
      ptw_pkg::OFS_MASK2: begin
        rd_word = mk_word(st_r.mask[1]);
      end
      ptw_pkg::OFS_DIAG: begin
        rd_word[ptw_pkg::NFLG-1:0] = eif.flags;
      end
      default: begin
        rd_word = ptw_pkg::RST_WORD;
      end
    endcase
  end

  // ----------------------------------------------------------
  // next state
  // ----------------------------------------------------------
  always_comb begin
    logic [ptw_pkg::DW-1:0] m;
    m = ptw_pkg::RST_WORD;
    st_nxt = st_r;
    // ack one cycle after the request, dropped after one cycle
    st_nxt.ack = req & ~st_r.ack;
    if (req && !st_r.ack) begin
      st_nxt.rdata = rd_word;
    end
    if (wr) begin
      case (wb_adr_i)
        ptw_pkg::OFS_TBASE1: begin
          m = (tb_word(st_r.tbase[0]) & ~wmask) | wword;
          st_nxt.tbase[0] = m[ptw_pkg::DW-1:ptw_pkg::TB_LO];
        end
        ptw_pkg::OFS_TBASE2: begin
          m = (tb_word(st_r.tbase[1]) & ~wmask) | wword;
          st_nxt.tbase[1] = m[ptw_pkg::DW-1:ptw_pkg::TB_LO];
        end
        ptw_pkg::OFS_WBASE1: begin
          m = (wb_word(st_r.base[0], st_r.wen[0], st_r.sg_mapping_enable_bit[0]) &
               ~wmask) | wword;
          st_nxt.base[0] = m[ptw_pkg::DW-1:ptw_pkg::WIN_LO];
          st_nxt.wen[0] = m[ptw_pkg::WEN_BIT];
          st_nxt.sg_mapping_enable_bit[0] = m[ptw_pkg::SG_MAPPING_ENABLE_BIT_BIT];
        end
        ptw_pkg::OFS_WBASE2: begin
          m = (wb_word(st_r.base[1], st_r.wen[1], st_r.sg_mapping_enable_bit[1]) &
               ~wmask) | wword;
          st_nxt.base[1] = m[ptw_pkg::DW-1:ptw_pkg::WIN_LO];
          st_nxt.wen[1] = m[ptw_pkg::WEN_BIT];
          st_nxt.sg_mapping_enable_bit[1] = m[ptw_pkg::SG_MAPPING_ENABLE_BIT_BIT];
        end
        ptw_pkg::OFS_MASK1: begin
          m = (mk_word(st_r.mask[0]) & ~wmask) | wword;
          st_nxt.mask[0] = m[ptw_pkg::DW-1:ptw_pkg::WIN_LO];
        end
        ptw_pkg::OFS_MASK2: begin
          m = (mk_word(st_r.mask[1]) & ~wmask) | wword;
          st_nxt.mask[1] = m[ptw_pkg::DW-1:ptw_pkg::WIN_LO];
        end
        default: begin
          m = ptw_pkg::RST_WORD;
        end
      endcase
    end
    // window 1 wins when both windows hit
    st_nxt.tvld = rvld;
    st_nxt.thit = rvld & (|rhit); // [R08]
    st_nxt.twin = ~rhit[0] & rhit[1];
    if (rhit[0]) begin
      st_nxt.tsg = rsg[0];
      st_nxt.taddr = raddr[0];
    end else if (rhit[1]) begin
      st_nxt.tsg = rsg[1];
      st_nxt.taddr = raddr[1];
    end else begin
      st_nxt.tsg = 1'b0;
      st_nxt.taddr = '0;
    end
    st_nxt.errv = |eif.flags[ptw_pkg::FLG_COR:ptw_pkg::FLG_MEM]; // [R02]
    if (srst) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdata;
  assign tgt_vld = st_r.tvld;
  assign tgt_hit = st_r.thit;
  assign tgt_win = st_r.twin;
  assign tgt_sg = st_r.tsg;
  assign tgt_cpu_addr = st_r.taddr;
  assign err_addr_valid = st_r.errv;
endmodule

/* testbench/ptw_top_sva.sv */
// ptw_top_sva: port checks of the window map top
// assumes: bound to ptw_top, single clock domain
`timescale 1ns/1ps
module ptw_top_sva (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // pci lookup
  input wire logic pci_req,
  input wire logic [ptw_pkg::DW-1:0] pci_addr,
  input wire logic tgt_vld,
  input wire logic tgt_hit,
  input wire logic tgt_sg,
  input wire logic [ptw_pkg::SAW-1:0] tgt_cpu_addr,
  // dma errors
  input wire logic memory_error_flag_ev,
  input wire logic uncorrectable_read_error_flag_ev,
  input wire logic correctable_read_error_flag_ev,
  input wire logic err_addr_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic ev;
  assign ev = memory_error_flag_ev | uncorrectable_read_error_flag_ev |
    correctable_read_error_flag_ev;
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |-> ##1 wb_ack_o) else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_vld_delay: assert property (pci_req |-> ##2 tgt_vld)
    else $error("answer late");
  a_vld_cause: assert property (tgt_vld |-> $past(pci_req, 2))
    else $error("answer without request");
  a_miss_zero: assert property (tgt_vld && !tgt_hit |->
    tgt_cpu_addr == '0) else $error("miss with address");
  a_direct_pass: assert property (tgt_vld && tgt_hit && !tgt_sg |->
    tgt_cpu_addr[19:0] == $past(pci_addr[19:0], 2))
    else $error("offset not passed");
  a_sg_entry: assert property (tgt_vld && tgt_sg |->
    tgt_cpu_addr[2:0] == 3'h0) else $error("entry misaligned");
  a_err_valid: assert property (ev |-> ##2 err_addr_valid)
    else $error("valid not raised");
  a_err_rise: assert property ($rose(err_addr_valid) |->
    $past(ev, 2)) else $error("valid without event");
  c_sg_hit: cover property (tgt_vld && tgt_hit && tgt_sg);
  c_direct: cover property (tgt_vld && tgt_hit && !tgt_sg);
  c_miss: cover property (tgt_vld && !tgt_hit);
  c_err: cover property ($rose(err_addr_valid));
endmodule
bind ptw_top ptw_top_sva u_sva (.clk, .srst, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .pci_req, .pci_addr, .tgt_vld, .tgt_hit, .tgt_sg,
  .tgt_cpu_addr, .memory_error_flag_ev, .uncorrectable_read_error_flag_ev,
  .correctable_read_error_flag_ev, .err_addr_valid);

/* testbench/ptw_pci_model.sv */
// ptw_pci_model: pci master issuing inbound lookups
// assumes: answers arrive on the tgt outputs of the top
`timescale 1ns/1ps
module ptw_pci_model (
  // clock
  input wire logic clk,
  // request
  output logic pci_req,
  output logic [ptw_pkg::DW-1:0] pci_addr,
  // answer
  input wire logic tgt_vld,
  input wire logic tgt_hit,
  input wire logic tgt_win,
  input wire logic tgt_sg,
  input wire logic [ptw_pkg::SAW-1:0] tgt_cpu_addr
);
  initial begin
    pci_req = 1'b0;
    pci_addr = 32'h0;
  end
  task automatic lookup(input logic [31:0] a, output logic [36:0] r);
    int n;
    n = 0;
    @(posedge clk);
    pci_req <= 1'b1;
    pci_addr <= a;
    @(posedge clk);
    pci_req <= 1'b0;
    // released lines carry no stale address
    pci_addr <= ~a;
    do begin
      @(posedge clk);
      n++;
    end while (tgt_vld !== 1'b1 && n < 8);
    // a missing answer fails every compare
    if (tgt_vld !== 1'b1) begin
      r = 'x;
    end else begin
      r = {tgt_hit, tgt_win, tgt_sg, tgt_cpu_addr};
    end
  endtask
endmodule

/* testbench/testbench.sv */
// testbench: scenarios for ptw_top
// assumes: pci model and bound checker beside the top
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, pci_req, tgt_vld, tgt_hit, tgt_win, tgt_sg;
  logic [31:0] pci_addr;
  logic [33:0] tgt_cpu_addr;
  logic [2:0] ev = 3'h0;
  logic [33:0] system_bus_address = 34'h0;
  logic err_addr_valid;
  logic [36:0] r;
  logic [36:0] x;
  logic [3:0] sel_v = 4'hf;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  ptw_top u_dut (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pci_req, .pci_addr,
    .tgt_vld, .tgt_hit, .tgt_win, .tgt_sg, .tgt_cpu_addr,
    .memory_error_flag_ev(ev[0]), .uncorrectable_read_error_flag_ev(ev[1]),
    .correctable_read_error_flag_ev(ev[2]), .system_bus_address,
    .err_addr_valid);
  ptw_pci_model u_pci (.clk, .pci_req, .pci_addr, .tgt_vld, .tgt_hit,
    .tgt_win, .tgt_sg, .tgt_cpu_addr);
  // ----
  // helpers
  // ----
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: word %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_tgt(input logic [36:0] got, input logic [36:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: answer %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= sel_v;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic pulse(input logic [2:0] k, input logic [33:0] a);
    @(posedge clk);
    ev <= k;
    system_bus_address <= a;
    @(posedge clk);
    ev <= 3'h0;
    system_bus_address <= ~a;
  endtask
  function automatic logic [33:0] dmap(input logic [31:0] t, m, p);
    logic [33:0] mk;
    mk = {2'h0, m[31:20], 20'hfffff};
    return ({1'b0, t[31:9], 10'h000} & ~mk) | ({2'h0, p} & mk);
  endfunction
  function automatic logic [33:0] smap(input logic [31:0] t, m, p);
    logic [33:0] mk;
    mk = {2'h0, m[31:20], 20'hfffff};
    return {1'b0, t[31:9], 10'h000} | ((({2'h0, p} & mk) >> 13) << 3);
  endfunction
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    wb(1'b1, 8'h20, 32'hffffffff);
    for (int a = 0; a <= 32; a += 4) begin
      wb(1'b0, 8'(a), 32'h0);
      chk_word(rd, 32'h0);
    end
  endtask
  task automatic t_window();
    wb(1'b1, ptw_pkg::OFS_MASK1, 32'h0010_0000);
    wb(1'b1, ptw_pkg::OFS_TBASE1, 32'h8765_4200);
    wb(1'b0, ptw_pkg::OFS_TBASE1, 32'h0);
    chk_word(rd, 32'h8765_4200);
    sel_v = 4'h2;
    wb(1'b1, ptw_pkg::OFS_TBASE1, 32'h0);
    sel_v = 4'hf;
    wb(1'b0, ptw_pkg::OFS_TBASE1, 32'h0);
    chk_word(rd, 32'h8765_0000);
    wb(1'b1, ptw_pkg::OFS_WBASE1, 32'h1230_0000);
    u_pci.lookup(32'h1225_6789, r);
    chk_tgt({r[36], 2'h0, r[33:0]}, 37'h0);
    wb(1'b1, ptw_pkg::OFS_WBASE1, 32'h1238_0000);
    u_pci.lookup(32'h1225_6789, r);
    x = {3'h4, dmap(32'h8765_0000, 32'h0010_0000, 32'h1225_6789)};
    chk_tgt(r, x);
    u_pci.lookup(32'h1245_0000, r);
    chk_tgt({r[36], 2'h0, r[33:0]}, 37'h0);
  endtask
  task automatic t_sg();
    wb(1'b1, ptw_pkg::OFS_WBASE2, 32'h0);
    wb(1'b1, ptw_pkg::OFS_MASK2, 32'h0030_0000);
    wb(1'b1, ptw_pkg::OFS_TBASE2, 32'h0abc_de00);
    wb(1'b1, ptw_pkg::OFS_WBASE2, 32'h400c_0000);
    u_pci.lookup(32'h4023_4567, r);
    x = {3'h7, smap(32'h0abc_de00, 32'h0030_0000, 32'h4023_4567)};
    chk_tgt(r, x);
  endtask
  task automatic t_err();
    pulse(3'h1, 34'h2_dead_bee0);
    repeat (3) @(posedge clk);
    chk_flag(err_addr_valid, 1'b1);
    wb(1'b1, ptw_pkg::OFS_SYS_ERR, 32'hffffffff);
    wb(1'b0, ptw_pkg::OFS_SYS_ERR, 32'h0);
    chk_word(rd, {28'hb7ab6fb, 4'h0});
    pulse(3'h2, 34'h1_2345_6780);
    wb(1'b0, ptw_pkg::OFS_SYS_ERR, 32'h0);
    chk_word(rd, {28'hb7ab6fb, 4'h0});
    wb(1'b0, ptw_pkg::OFS_DIAG, 32'h0);
    chk_word(rd & 32'h9, 32'h9);
    wb(1'b1, ptw_pkg::OFS_DIAG, 32'hf);
    repeat (3) @(posedge clk);
    chk_flag(err_addr_valid, 1'b0);
    pulse(3'h4, 34'h1_2345_6780);
    wb(1'b0, ptw_pkg::OFS_SYS_ERR, 32'h0);
    chk_word(rd, {28'h48d159e, 4'h0});
  endtask
  task automatic t_midrst();
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk_flag(err_addr_valid, 1'b0);
    wb(1'b0, ptw_pkg::OFS_DIAG, 32'h0);
    chk_word(rd, 32'h0);
    wb(1'b0, ptw_pkg::OFS_WBASE1, 32'h0);
    chk_word(rd, 32'h0);
    u_pci.lookup(32'h1225_6789, r);
    chk_tgt({r[36], 2'h0, r[33:0]}, 37'h0);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_window();
    t_sg();
    t_err();
    t_midrst();
    end_of_test();
  end
endmodule
